// *** rtl/charger_defines.vh ***
// Constants for the charger control register slice
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// ----------------------------------------------------------------
// Serial slave addresses (7-bit form of the 8-bit write address)
// ----------------------------------------------------------------
`define ADDR_PRIMARY 7'h6b
`define ADDR_SECONDARY 7'h6a

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define REG_CTRL 8'h01
`define REG_FLOAT 8'h02
`define REG_ID 8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_HIZ_BIT 1
`define CTRL_BOOST_SEL_BIT 0
`define FLOAT_CODE_MSB 7
`define FLOAT_CODE_LSB 2
`define FLOAT_POL_BIT 1
`define FLOAT_EN_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RESET 2'h0
`define FLOAT_RESET 8'h0a

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAFETY_TIMEOUT_MIN 15
`define SECONDS_PER_MIN 60
`define MCLK_HZ 250000000

`endif

// *** rtl/input_sync.v ***
// Two-flop synchroniser for a group of asynchronous inputs
module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] reset_level = {WIDTH{1'b1}}
) (
  input wire mclk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // Reset to each pin's idle level, so no false edge follows reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= reset_level;
      sync_out <= reset_level;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** rtl/charger_control_registers.v ***
// Charger control registers behind a two-wire serial slave
//
// Operation
// - Safety timeout sets USB high-impedance bit
// - High-impedance bit drives USB path off
// - Boost select forces boost unless high-impedance
// - Float code bits 7:2, reset 000010
// - Float register primary address only, reset 0x0a
// - Polarity bit: 0 active low, 1 high
// - Pin enable bit gates request pin
// - Identification register answers at both addresses
`include "charger_defines.vh"

module charger_control_registers #(
  parameter [39:0] safety_timeout_cycles = 40'd`SAFETY_TIMEOUT_MIN *
    40'd`SECONDS_PER_MIN * 40'd`MCLK_HZ,
  parameter [2:0] supplier_code = 3'h5,  // Arbitrary value
  parameter [1:0] part_code = 2'h1,      // Arbitrary value
  parameter [2:0] revision_code = 3'h1   // Arbitrary value
) (
  input wire mclk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire boost_req_pin,
  input wire charge_active,
  output reg usb_path_high_impedance,
  output reg boost_on,
  output reg [5:0] float_voltage_code
);

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ADDR = 8'h02;
  localparam [7:0] ST_AACK = 8'h04;
  localparam [7:0] ST_WBYTE = 8'h08;
  localparam [7:0] ST_WACK = 8'h10;
  localparam [7:0] ST_RDATA = 8'h20;
  localparam [7:0] ST_RACK = 8'h40;

  // Reset images, sliced per field below
  localparam [1:0] ctrl_reset_v = `CTRL_RESET;
  localparam [7:0] float_reset_v = `FLOAT_RESET;

  wire [3:0] sync_w;
  wire scl_s = sync_w[0];
  wire sda_s = sync_w[1];
  wire req_s = sync_w[2];
  wire charge_s = sync_w[3];

  input_sync #(.WIDTH(4), .reset_level(4'h3)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({charge_active, boost_req_pin, sda_in, scl_in}),
    .sync_out(sync_w)
  );

  reg scl_q, sda_q;
  reg [7:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg primary_q;
  reg ptr_phase_q;
  reg nack_q;
  reg hiz_q;
  reg boost_sel_q;
  reg [7:0] float_q;
  reg [39:0] timer_q;
  reg timeout_q;

  wire start_w = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_w = scl_s & scl_q & ~sda_q & sda_s;
  wire rise_w = scl_s & ~scl_q;
  wire fall_w = ~scl_s & scl_q;
  wire [6:0] addr_w = rx_q[7:1];
  wire addr_hit_w = (addr_w == `ADDR_PRIMARY) ||
    (addr_w == `ADDR_SECONDARY);
  wire wr_w = (state_q == ST_WBYTE) && fall_w && (cnt_q == 4'd8) &&
    !ptr_phase_q && primary_q;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  reg [7:0] rdata_w;
  always @* begin
    rdata_w = 8'h00;
    if (ptr_q == `REG_ID) begin
      rdata_w = {supplier_code, part_code, revision_code};
    end else if (primary_q && ptr_q == `REG_CTRL) begin
      rdata_w = {6'h00, hiz_q, boost_sel_q};
    end else if (primary_q && ptr_q == `REG_FLOAT) begin
      rdata_w = float_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      primary_q <= 1'b0;
      ptr_phase_q <= 1'b0;
      nack_q <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sda_out <= 1'b0;
      if (start_w) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_w) begin
        state_q <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state_q)
          ST_ADDR, ST_WBYTE: begin
            if (rise_w && cnt_q != 4'd8) begin
              rx_q <= {rx_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'd1;
            end else if (fall_w && cnt_q == 4'd8) begin
              if (state_q == ST_WBYTE) begin
                sda_oe_n <= 1'b0;
                state_q <= ST_WACK;
                if (ptr_phase_q) begin
                  ptr_q <= rx_q;
                end else begin
                  ptr_q <= ptr_q + 8'd1;
                end
              end else if (addr_hit_w) begin
                sda_oe_n <= 1'b0;
                state_q <= ST_AACK;
                rw_q <= rx_q[0];
                primary_q <= (addr_w == `ADDR_PRIMARY);
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (fall_w) begin
              cnt_q <= 4'h0;
              if (state_q == ST_AACK && rw_q) begin
                tx_q <= rdata_w;
                sda_oe_n <= rdata_w[7];
                ptr_q <= ptr_q + 8'd1;
                state_q <= ST_RDATA;
              end else begin
                sda_oe_n <= 1'b1;
                ptr_phase_q <= (state_q == ST_AACK);
                state_q <= ST_WBYTE;
              end
            end
          end
          ST_RDATA: begin
            if (rise_w) begin
              cnt_q <= cnt_q + 4'd1;
            end else if (fall_w) begin
              if (cnt_q == 4'd8) begin
                sda_oe_n <= 1'b1;
                state_q <= ST_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_n <= tx_q[6];
              end
            end
          end
          ST_RACK: begin
            if (rise_w) begin
              nack_q <= sda_s;
            end else if (fall_w) begin
              cnt_q <= 4'h0;
              if (!nack_q) begin
                tx_q <= rdata_w;
                sda_oe_n <= rdata_w[7];
                ptr_q <= ptr_q + 8'd1;
                state_q <= ST_RDATA;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Safety timer
  // ----------------------------------------------------------------
  // Saturates at expiry so the flag is raised once per charge cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= 40'h0;
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (!charge_s) begin
        timer_q <= 40'h0;
      end else if (timer_q != safety_timeout_cycles) begin
        timer_q <= timer_q + 40'd1;
        timeout_q <= (timer_q == safety_timeout_cycles - 40'd1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hiz_q <= ctrl_reset_v[`CTRL_HIZ_BIT];
      boost_sel_q <= ctrl_reset_v[`CTRL_BOOST_SEL_BIT];
      float_q <= float_reset_v;
    end else begin
      if (wr_w && ptr_q == `REG_CTRL) begin
        boost_sel_q <= rx_q[`CTRL_BOOST_SEL_BIT];
      end
      // Timeout wins over a same-cycle clearing write
      if (timeout_q) begin
        hiz_q <= 1'b1;
      end else if (wr_w && ptr_q == `REG_CTRL) begin
        hiz_q <= rx_q[`CTRL_HIZ_BIT];
      end
      if (wr_w && ptr_q == `REG_FLOAT) begin
        float_q <= rx_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire pin_asserted_w = ~(req_s ^ float_q[`FLOAT_POL_BIT]);
  wire pin_boost_w = pin_asserted_w & float_q[`FLOAT_EN_BIT];

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      usb_path_high_impedance <= 1'b0;
      boost_on <= 1'b0;
      float_voltage_code <= float_reset_v[`FLOAT_CODE_MSB:`FLOAT_CODE_LSB];
    end else begin
      usb_path_high_impedance <= hiz_q;
      boost_on <= ~hiz_q & (boost_sel_q | pin_boost_w);
      float_voltage_code <=
        float_q[`FLOAT_CODE_MSB:`FLOAT_CODE_LSB];
    end
  end

endmodule

// *** bench/charger_control_registers_asserts.sv ***
// Port assertions for the charger register slice
module charger_control_registers_asserts #(
  parameter [39:0] safety_timeout_cycles = 40'd100
) (
  input wire mclk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire boost_req_pin,
  input wire charge_active,
  input wire usb_path_high_impedance,
  input wire boost_on,
  input wire [5:0] float_voltage_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] run_q;
  // Margin of 8 covers input sync and output register
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) run_q <= 40'd0;
    else run_q <= charge_active ? run_q + 40'd1 : 40'd0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_idle_after_reset: assert property (
    $rose(reset_n) |-> !usb_path_high_impedance && !boost_on)
    else $error("outputs not idle after reset");
  a_float_default: assert property (
    $rose(reset_n) |-> float_voltage_code == 6'h02)
    else $error("float code not at default");
  a_hiz_blocks_boost: assert property (
    usb_path_high_impedance && $past(usb_path_high_impedance)
    |-> !boost_on) else $error("boost while high impedance");
  a_timeout_sets_hiz: assert property (
    run_q == safety_timeout_cycles + 40'd8 |-> usb_path_high_impedance)
    else $error("safety timeout did not set high impedance");
  a_float_write_acked: assert property (
    $changed(float_voltage_code) |-> ##[1:8] !sda_oe_n)
    else $error("float code changed without ack");
  a_float_scl_low: assert property (
    $changed(float_voltage_code) |-> !scl_in)
    else $error("float code changed with clock high");
  a_sda_steady_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data drive changed with clock high");
  a_drive_low_only: assert property (
    !sda_oe_n |-> !sda_out) else $error("data driven high");
endmodule
bind charger_control_registers charger_control_registers_asserts #(
  .safety_timeout_cycles(safety_timeout_cycles)
) charger_control_registers_asserts_inst (
  .mclk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .boost_req_pin, .charge_active, .usb_path_high_impedance,
  .boost_on, .float_voltage_code
);

// *** bench/serial_host_model.sv ***
// Two-wire bus host model for register reads and writes
module serial_host_model (
  input wire mclk,
  input wire sda_out,
  input wire sda_oe_n,
  output logic scl_in,
  output wire sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low = 1'b0;
  // Pull-up: a released line reads high
  assign sda_in = ~pull_low & (sda_oe_n | sda_out);
  initial scl_in = 1'b1;
  // ------
  // Bus phases
  // ------
  // Six cycles a quarter keeps the low phase at twelve
  task automatic quarter();
    repeat (6) @(negedge mclk);
  endtask
  task automatic put_bit(input logic b, input logic c, output logic s);
    pull_low = ~b;
    quarter();
    scl_in = 1'b1;
    quarter();
    s = sda_in;
    // Data is held past the clock fall; only start and stop pull here
    if (c) pull_low = 1'b1;
    scl_in = c;
    quarter();
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], 1'b0, s);
      q[i] = s;
    end
    put_bit(1'b1, 1'b0, s);
    ack = ~s;
  endtask
  task automatic xact(input logic rd, input logic [6:0] a,
                      input logic [7:0] idx, d, output logic [7:0] q,
                      output logic ok);
    logic s, k0, k1, k2, k3;
    put_bit(1'b1, 1'b1, s);
    put_bit(1'b0, 1'b0, s);
    xfer({a, 1'b0}, q, k0);
    xfer(idx, q, k1);
    if (rd) begin
      put_bit(1'b1, 1'b1, s);
      put_bit(1'b0, 1'b0, s);
      xfer({a, 1'b1}, q, k2);
      xfer(8'hff, q, k3);
    end else begin
      xfer(d, q, k2);
    end
    put_bit(1'b0, 1'b1, s);
    pull_low = 1'b0;
    quarter();
    ok = k0 & k1 & k2;
  endtask
endmodule

// *** bench/charger_control_registers_tb.sv ***
// Testbench for the charger control register slice
`include "charger_defines.vh"
module charger_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic boost_req_pin = 1'b0;
  logic charge_active = 1'b0;
  wire scl_in, sda_in, sda_out, sda_oe_n, usb_path_high_impedance;
  wire boost_on;
  wire [5:0] float_voltage_code;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] rdata;
  logic ok;
  always #2 mclk = ~mclk;
  // Identity values below are arbitrary
  charger_control_registers #(
    .safety_timeout_cycles(40'd100), .supplier_code(3'h3),
    .part_code(2'h1), .revision_code(3'h6)
  ) charger_control_registers_inst (
    .mclk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .boost_req_pin, .charge_active, .usb_path_high_impedance,
    .boost_on, .float_voltage_code
  );
  serial_host_model serial_host_model_inst (
    .mclk, .sda_out, .sda_oe_n, .scl_in, .sda_in
  );
  // ------
  // Checking and bus helpers
  // ------
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic io(input logic rd, input logic [6:0] a,
                    input logic [7:0] i, d);
    serial_host_model_inst.xact(rd, a, i, d, rdata, ok);
    check("ack", ok, 8'h01);
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    check("code", float_voltage_code, 8'h02);
    check("hiz", usb_path_high_impedance, 8'h00);
    io(1'b1, `ADDR_PRIMARY, `REG_FLOAT, 8'h00);
    check("float", rdata, 8'h0a);
  endtask
  task automatic t_float();
    io(1'b0, `ADDR_PRIMARY, `REG_FLOAT, 8'hfe);
    check("code", float_voltage_code, 8'h3f);
    io(1'b0, `ADDR_SECONDARY, `REG_FLOAT, 8'h00);
    io(1'b1, `ADDR_PRIMARY, `REG_FLOAT, 8'h00);
    check("float kept", rdata, 8'hfe);
    io(1'b1, `ADDR_SECONDARY, `REG_FLOAT, 8'h00);
    check("float sec", rdata, 8'h00);
  endtask
  task automatic t_id();
    io(1'b0, `ADDR_PRIMARY, `REG_ID, 8'h00);
    io(1'b1, `ADDR_PRIMARY, `REG_ID, 8'h00);
    check("id pri", rdata, 8'h6e);
    io(1'b1, `ADDR_SECONDARY, `REG_ID, 8'h00);
    check("id sec", rdata, 8'h6e);
  endtask
  task automatic t_timer();
    io(1'b0, `ADDR_PRIMARY, `REG_CTRL, 8'h00);
    charge_active = 1'b1;
    repeat (90) @(negedge mclk);
    check("hiz early", usb_path_high_impedance, 8'h00);
    repeat (20) @(negedge mclk);
    check("hiz late", usb_path_high_impedance, 8'h01);
    charge_active = 1'b0;
    io(1'b1, `ADDR_PRIMARY, `REG_CTRL, 8'h00);
    check("ctrl", rdata, 8'h02);
  endtask
  // Every polarity, enable, pin, select and high-impedance mix
  task automatic t_boost();
    logic want;
    for (int pe = 0; pe < 4; pe++) begin
      io(1'b0, `ADDR_PRIMARY, `REG_FLOAT, {6'h02, pe[1:0]});
      for (int hs = 0; hs < 4; hs++) begin
        io(1'b0, `ADDR_PRIMARY, `REG_CTRL, {6'h00, hs[1:0]});
        check("hiz", usb_path_high_impedance, hs[1]);
        for (int p = 0; p < 2; p++) begin
          boost_req_pin = p[0];
          repeat (8) @(negedge mclk);
          want = !hs[1] && (hs[0] || (pe[0] && p[0] == pe[1]));
          check("boost", boost_on, want);
        end
      end
    end
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_float();
    t_id();
    t_timer();
    t_boost();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    conclude();
  end
endmodule
